// file: hw/iscr_pkg.sv
// iscr_pkg: constants, types and state codes of the i2c seconds counter rtc.
// assumes one 40 MHz system clock; every pin is sampled through iscr_sync.
`default_nettype none

package iscr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [2:0] ADDR_COUNT0 = 3'h0;
    localparam logic [2:0] ADDR_COUNT1 = 3'h1;
    localparam logic [2:0] ADDR_COUNT2 = 3'h2;
    localparam logic [2:0] ADDR_COUNT3 = 3'h3;
    localparam logic [2:0] ADDR_OSC_CTRL = 3'h4;
    localparam logic [2:0] ADDR_CHARGE = 3'h5;
    localparam logic [2:0] ADDR_LAST = 3'h5;
    localparam int COUNT_BYTES = 4;
    localparam int OSC_DISABLE_BIT = 7;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic OSC_DISABLE_RESET = 1'b0;
    localparam logic [7:0] CHARGE_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // charge-select field codes
    localparam logic [3:0] KEY_ENABLE = 4'ha;
    localparam logic [1:0] DIODE_NONE = 2'h1;
    localparam logic [1:0] DIODE_ONE = 2'h2;
    localparam logic [1:0] RES_OFF = 2'h0;

    typedef struct packed {
        logic [3:0] charge_enable_key;
        logic [1:0] diode_select;
        logic [1:0] resistor_choice;
    } iscr_charge_t;

    // pin group sampled into the clock domain
    typedef struct packed {
        logic scl;
        logic sda;
        logic crystal_in;
        logic power_fail;
    } iscr_pins_t;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int MCLK_HZ = 40_000_000;
    localparam int PRESCALE_DIV = 32768;
    localparam int PRESCALE_W = 15;
    localparam int RELEASE_DELAY_MS = 250;
    localparam int OSC_STARTUP_MS = 1000;
    localparam int RELEASE_CYCLES = RELEASE_DELAY_MS * (MCLK_HZ / 1000);
    localparam int STARTUP_CYCLES = OSC_STARTUP_MS * (MCLK_HZ / 1000);

    ////////////////////////////////////////////////////////////////////////
    // serial port states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_REG,
        ST_WDATA,
        ST_ACK,
        ST_READ,
        ST_MACK
    } iscr_state_t;

endpackage

`default_nettype wire

// file: hw/iscr_sync.sv
// iscr_sync: two-flop synchronisers with edge detection, one per bit.
// assumes the inputs are asynchronous to mclk and slower than it.
`timescale 1ns/1ps
`default_nettype none

module iscr_sync #(
    parameter int W = 4
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         resetn,
    // asynchronous inputs
    input  wire logic [W-1:0] d,
    // synchronised level and edges
    output var  logic [W-1:0] q,
    output var  logic [W-1:0] rise,
    output var  logic [W-1:0] fall
);

    logic [W-1:0] meta;
    logic [W-1:0] q_d;

    ////////////////////////////////////////////////////////////////////////
    // scl and sda idle high (pull-ups), so reset every bit to ones to avoid a false edge on them
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta <= '1;
            q <= '1;
            q_d <= '1;
        end else begin
            meta <= d;
            q <= meta;
            q_d <= q;
        end
    end

    always_comb begin
        rise = q & ~q_d;
        fall = ~q & q_d;
    end

endmodule

`default_nettype wire

// file: hw/iscr_top.sv
// iscr_top: seconds counter rtc with i2c slave port, power monitor and
// open-drain reset. assumes scl, sda, crystal_in and power_fail arrive
// asynchronously and are much slower than mclk (40 MHz).
`timescale 1ns/1ps
`default_nettype none

module iscr_top #(
    parameter logic [6:0] DEV_ADDR = 7'h2a,  // arbitrary value
    parameter int RELEASE_CYCLES = iscr_pkg::RELEASE_CYCLES,
    parameter int STARTUP_CYCLES = iscr_pkg::STARTUP_CYCLES
) (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       resetn,
    // two-wire bus
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output var  logic       sda_out,
    output var  logic       sda_oe,
    // timebase and supply monitor
    input  wire logic       crystal_in,
    input  wire logic       power_fail,
    // reset output, open drain
    output var  logic       rst_n_out,
    output var  logic       rst_n_oe,
    // charge path control
    output var  logic       charge_on,
    output var  logic       charge_diode,
    output var  logic [1:0] charge_res
);

    ////////////////////////////////////////////////////////////////////////
    // pin sampling

    iscr_pkg::iscr_pins_t pins_q;
    iscr_pkg::iscr_pins_t pins_rise;
    iscr_pkg::iscr_pins_t pins_fall;
    logic                 access_ok;
    logic                 start_cond;
    logic                 stop_cond;

    iscr_sync #(
        .W($bits(iscr_pkg::iscr_pins_t))
    ) u_sync (
        .mclk  (mclk),
        .resetn(resetn),
        .d     ({scl_in, sda_in, crystal_in, power_fail}),
        .q     (pins_q),
        .rise  (pins_rise),
        .fall  (pins_fall)
    );

    always_comb begin
        access_ok = ~pins_q.power_fail;
        start_cond = pins_q.scl & pins_fall.sda;
        stop_cond = pins_q.scl & pins_rise.sda;
    end

    ////////////////////////////////////////////////////////////////////////
    // register state

    logic [31:0]          count;
    logic                 osc_disable;
    iscr_pkg::iscr_charge_t charge;
    logic [14:0]          prescale;
    logic [31:0]          next_count;
    logic                 next_osc_disable;
    iscr_pkg::iscr_charge_t next_charge;
    logic [14:0]          next_prescale;
    logic                 sec_tick;
    logic                 wr_en;
    logic [2:0]           wr_addr;
    logic [7:0]           wr_data;

    function automatic logic [7:0] reg_byte(input logic [2:0] a);
        case (a)
            iscr_pkg::ADDR_COUNT0: reg_byte = count[7:0];
            iscr_pkg::ADDR_COUNT1: reg_byte = count[15:8];
            iscr_pkg::ADDR_COUNT2: reg_byte = count[23:16];
            iscr_pkg::ADDR_COUNT3: reg_byte = count[31:24];
            iscr_pkg::ADDR_OSC_CTRL: reg_byte = {osc_disable, 7'h00};
            iscr_pkg::ADDR_CHARGE: reg_byte = charge;
            default: reg_byte = 8'h00;
        endcase
    endfunction

    function automatic logic [2:0] ptr_inc(input logic [2:0] a);
        ptr_inc = (a == iscr_pkg::ADDR_LAST) ? iscr_pkg::ADDR_COUNT0 : 3'(a + 3'h1);
    endfunction

    // counting ignores power_fail, so time survives on the backup supply
    always_comb begin
        next_prescale = prescale;
        sec_tick = 1'b0;
        if (pins_rise.crystal_in && !osc_disable) begin
            next_prescale = 15'(prescale + 15'h1);
            sec_tick = (prescale == 15'(iscr_pkg::PRESCALE_DIV - 1));
        end
        next_count = sec_tick ? 32'(count + 32'h1) : count;
        next_osc_disable = osc_disable;
        next_charge = charge;
        if (wr_en) begin
            for (int i = 0; i < iscr_pkg::COUNT_BYTES; i++) begin
                if (wr_addr == 3'(i)) begin
                    next_count[8*i +: 8] = wr_data;
                end
            end
            if (wr_addr == iscr_pkg::ADDR_OSC_CTRL) begin
                next_osc_disable = wr_data[iscr_pkg::OSC_DISABLE_BIT];
            end
            if (wr_addr == iscr_pkg::ADDR_CHARGE) begin
                next_charge = wr_data;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            count <= iscr_pkg::COUNT_RESET;
            osc_disable <= iscr_pkg::OSC_DISABLE_RESET;
            charge <= iscr_pkg::CHARGE_RESET;
            prescale <= '0;
        end else begin
            count <= next_count;
            osc_disable <= next_osc_disable;
            charge <= next_charge;
            prescale <= next_prescale;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial slave: only answers, never drives scl

    iscr_pkg::iscr_state_t state;
    iscr_pkg::iscr_state_t after_ack;
    iscr_pkg::iscr_state_t next_state;
    iscr_pkg::iscr_state_t next_after_ack;
    logic [7:0]           shreg;
    logic [7:0]           next_shreg;
    logic [3:0]           bitcnt;
    logic [3:0]           next_bitcnt;
    logic [2:0]           ptr;
    logic [2:0]           next_ptr;
    logic                 nack;
    logic                 next_nack;
    logic                 next_sda_oe;
    logic [7:0]           rd_byte;

    always_comb begin
        next_state = state;
        next_after_ack = after_ack;
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_ptr = ptr;
        next_nack = nack;
        next_sda_oe = sda_oe;
        wr_en = 1'b0;
        wr_addr = ptr;
        wr_data = shreg;
        rd_byte = reg_byte(ptr);
        if (!access_ok) begin
            next_state = iscr_pkg::ST_IDLE;
            next_sda_oe = 1'b0;
        end else if (start_cond) begin
            next_state = iscr_pkg::ST_DEV;
            next_bitcnt = 4'h0;
            next_sda_oe = 1'b0;
        end else if (stop_cond) begin
            next_state = iscr_pkg::ST_IDLE;
            next_sda_oe = 1'b0;
        end else begin
            case (state)
                iscr_pkg::ST_DEV, iscr_pkg::ST_REG, iscr_pkg::ST_WDATA: begin
                    if (pins_rise.scl) begin
                        next_shreg = {shreg[6:0], pins_q.sda};
                        next_bitcnt = 4'(bitcnt + 4'h1);
                    end else if (pins_fall.scl && bitcnt == 4'h8) begin
                        next_bitcnt = 4'h0;
                        next_state = iscr_pkg::ST_ACK;
                        next_sda_oe = 1'b1;
                        if (state == iscr_pkg::ST_DEV) begin
                            next_after_ack = shreg[0] ? iscr_pkg::ST_READ
                                                      : iscr_pkg::ST_REG;
                            if (shreg[7:1] != DEV_ADDR) begin
                                next_state = iscr_pkg::ST_IDLE;
                                next_sda_oe = 1'b0;
                            end
                        end else if (state == iscr_pkg::ST_REG) begin
                            // out-of-map addresses start from byte zero
                            next_ptr = (shreg > 8'(iscr_pkg::ADDR_LAST)) ?
                                       iscr_pkg::ADDR_COUNT0 : shreg[2:0];
                            next_after_ack = iscr_pkg::ST_WDATA;
                        end else begin
                            wr_en = 1'b1;
                            next_ptr = ptr_inc(ptr);
                        end
                    end
                end
                iscr_pkg::ST_ACK: begin
                    if (pins_fall.scl) begin
                        next_state = after_ack;
                        next_sda_oe = 1'b0;
                        if (after_ack == iscr_pkg::ST_READ) begin
                            next_shreg = rd_byte;
                            next_ptr = ptr_inc(ptr);
                            next_sda_oe = ~rd_byte[7];
                        end
                    end
                end
                iscr_pkg::ST_READ: begin
                    if (pins_fall.scl) begin
                        if (bitcnt == 4'h7) begin
                            next_state = iscr_pkg::ST_MACK;
                            next_sda_oe = 1'b0;
                        end else begin
                            next_shreg = {shreg[6:0], 1'b0};
                            next_bitcnt = 4'(bitcnt + 4'h1);
                            next_sda_oe = ~shreg[6];
                        end
                    end
                end
                iscr_pkg::ST_MACK: begin
                    if (pins_rise.scl) begin
                        next_nack = pins_q.sda;
                    end else if (pins_fall.scl) begin
                        next_bitcnt = 4'h0;
                        if (nack) begin
                            next_state = iscr_pkg::ST_IDLE;
                        end else begin
                            next_state = iscr_pkg::ST_READ;
                            next_shreg = rd_byte;
                            next_ptr = ptr_inc(ptr);
                            next_sda_oe = ~rd_byte[7];
                        end
                    end
                end
                default: begin
                    next_sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= iscr_pkg::ST_IDLE;
            after_ack <= iscr_pkg::ST_IDLE;
            shreg <= 8'h00;
            bitcnt <= 4'h0;
            ptr <= iscr_pkg::ADDR_COUNT0;
            nack <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            state <= next_state;
            after_ack <= next_after_ack;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            ptr <= next_ptr;
            nack <= next_nack;
            sda_oe <= next_sda_oe;
            sda_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power monitor and reset release delay

    logic [31:0] hold_cnt;
    logic [31:0] next_hold_cnt;
    logic        next_rst_n_oe;
    logic [31:0] hold_limit;

    always_comb begin
        hold_limit = osc_disable ? 32'(RELEASE_CYCLES + STARTUP_CYCLES)
                                 : 32'(RELEASE_CYCLES);
        next_hold_cnt = hold_cnt;
        next_rst_n_oe = rst_n_oe;
        if (pins_q.power_fail) begin
            next_hold_cnt = 32'h0;
            next_rst_n_oe = 1'b1;
        end else if (rst_n_oe) begin
            if (hold_cnt >= 32'(hold_limit - 32'h1)) begin
                next_rst_n_oe = 1'b0;
            end else begin
                next_hold_cnt = 32'(hold_cnt + 32'h1);
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hold_cnt <= 32'h0;
            rst_n_oe <= 1'b1;
            rst_n_out <= 1'b0;
        end else begin
            hold_cnt <= next_hold_cnt;
            rst_n_oe <= next_rst_n_oe;
            rst_n_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // charge path decode

    logic next_charge_on;

    always_comb begin
        next_charge_on = (charge.charge_enable_key == iscr_pkg::KEY_ENABLE) &&
                         (charge.diode_select == iscr_pkg::DIODE_NONE ||
                          charge.diode_select == iscr_pkg::DIODE_ONE) &&
                         (charge.resistor_choice != iscr_pkg::RES_OFF);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            charge_on <= 1'b0;
            charge_diode <= 1'b0;
            charge_res <= iscr_pkg::RES_OFF;
        end else begin
            charge_on <= next_charge_on;
            charge_diode <= next_charge_on &&
                            charge.diode_select == iscr_pkg::DIODE_ONE;
            charge_res <= next_charge_on ? charge.resistor_choice : iscr_pkg::RES_OFF;
        end
    end

endmodule

`default_nettype wire

// file: tb/iscr_top_props.sv
// iscr_top_props: port-level checker for iscr_top.
// assumes the bench binds it onto iscr_top and passes the shortened counts.
`timescale 1ns/1ps
`default_nettype none

module iscr_top_props #(
    parameter int RELEASE_CYCLES = 50,
    parameter int STARTUP_CYCLES = 30
) (
    // clock and reset
    input wire logic       mclk,
    input wire logic       resetn,
    // bus and pins
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       crystal_in,
    input wire logic       power_fail,
    // outputs
    input wire logic       rst_n_out,
    input wire logic       rst_n_oe,
    input wire logic       charge_on,
    input wire logic       charge_diode,
    input wire logic [1:0] charge_res
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////
    // cycles since power_fail went low, saturating
    int low_cnt;
    int next_low_cnt;

    always_comb begin
        next_low_cnt = low_cnt;
        if (power_fail) begin
            next_low_cnt = 0;
        end else if (low_cnt < 1000) begin
            next_low_cnt = low_cnt + 1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            low_cnt <= 0;
        end else begin
            low_cnt <= next_low_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // long enough for the synchroniser to have seen it
    sequence pf_held;
        power_fail [*5];
    endsequence

    sda_drain_a: assert property (sda_out == 1'b0)
        else $error("sda driven high");
    rst_drain_a: assert property (rst_n_out == 1'b0)
        else $error("reset pin driven high");
    pf_reset_a: assert property (pf_held |-> rst_n_oe)
        else $error("reset not held in power fail");
    pf_quiet_a: assert property (pf_held |-> !sda_oe)
        else $error("bus answered in power fail");
    pf_frozen_a: assert property (pf_held |=> $stable({charge_on, charge_diode, charge_res}))
        else $error("register changed in power fail");
    // reset lags a rising power_fail by the synchroniser, so only judge low phases
    hold_min_a: assert property (!power_fail && low_cnt < RELEASE_CYCLES - 1 |-> rst_n_oe)
        else $error("reset released early");
    hold_max_a: assert property (low_cnt == RELEASE_CYCLES + STARTUP_CYCLES + 8 |-> !rst_n_oe)
        else $error("reset held too long");
    charge_res_a: assert property (charge_on == (charge_res != 2'h0))
        else $error("resistor code disagrees with enable");
    sda_hold_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("sda moved while scl high");
endmodule

`default_nettype wire

// file: tb/iscr_master_model.sv
// iscr_master_model: behavioural two-wire bus master, 200 ns bit period.
// assumes sda is the resolved wire with a pull-up; steps on mclk edges.
`timescale 1ns/1ps
`default_nettype none

module iscr_master_model (
    // clock
    input  wire logic mclk,
    // bus
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic hp(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // also a repeated start: scl is low on entry then
    task automatic start();
        sda_low <= 1'b0;
        hp(4);
        scl <= 1'b1;
        hp(4);
        sda_low <= 1'b1;
        hp(4);
        scl <= 1'b0;
    endtask

    task automatic stop();
        hp(2);
        sda_low <= 1'b1;
        hp(2);
        scl <= 1'b1;
        hp(4);
        sda_low <= 1'b0;
        hp(4);
    endtask

    // sample late in the high phase, where the slave's bit has settled
    task automatic bitx(input logic b, output logic s);
        hp(2);
        sda_low <= !b;
        hp(2);
        scl <= 1'b1;
        hp(3);
        @(negedge mclk);
        s = sda;
        @(posedge mclk);
        scl <= 1'b0;
    endtask

    task automatic xfer(input logic [7:0] d, input logic nine,
                        output logic [7:0] q, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], s);
            q[i] = s;
        end
        bitx(nine, s);
        ack = !s;
    endtask
endmodule

`default_nettype wire

// file: tb/iscr_top_tb.sv
// iscr_top_tb: self-checking bench for iscr_top.
// assumes shortened reset-release counts; crystal stands still between bursts.
`timescale 1ns/1ps
`default_nettype none

module iscr_top_tb;
    localparam int REL = 50;
    localparam int STU = 30;
    localparam logic [6:0] DEV = 7'h2a;  // arbitrary value

    logic       mclk = 1'b0;
    logic       resetn = 1'b0;
    logic       xtal = 1'b0;
    logic       pf = 1'b0;
    wire logic  scl, sda_low, sda, sda_out, sda_oe, rst_n_out, rst_n_oe, c_on, c_d;
    wire logic  rst_pin;
    wire logic [1:0] c_res;
    logic [7:0] wq [$];
    logic [7:0] rq [$];
    logic       nak;
    int         num_errors = 0;
    int         tests_run = 0;

    always #12.5 mclk = ~mclk;
    // pull-ups on both open-drain wires
    assign sda = !((sda_oe && !sda_out) || sda_low);
    assign rst_pin = !(rst_n_oe && !rst_n_out);

    iscr_master_model m (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));

    iscr_top #(.DEV_ADDR(DEV), .RELEASE_CYCLES(REL), .STARTUP_CYCLES(STU)) uut (
        .mclk(mclk), .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .crystal_in(xtal), .power_fail(pf), .rst_n_out(rst_n_out),
        .rst_n_oe(rst_n_oe), .charge_on(c_on), .charge_diode(c_d), .charge_res(c_res));

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        if (num_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic edges(input int n);
        // one cycle per level keeps a full second of edges inside the run budget
        repeat (n) begin
            xtal <= 1'b1;
            cyc(1);
            xtal <= 1'b0;
            cyc(1);
        end
    endtask

    task automatic wb(input logic [7:0] d);
        logic [7:0] q;
        logic a;
        m.xfer(d, 1'b1, q, a);
        nak = nak | !a;
    endtask

    task automatic rb(input logic last);
        logic [7:0] q;
        logic a;
        m.xfer(8'hff, last, q, a);
        rq.push_back(q);
    endtask

    task automatic wr(input logic [7:0] a);
        nak = 1'b0;
        m.start();
        wb({DEV, 1'b0});
        wb(a);
        foreach (wq[i]) wb(wq[i]);
        m.stop();
    endtask

    task automatic rd(input logic [7:0] a, input int n);
        nak = 1'b0;
        rq.delete();
        m.start();
        wb({DEV, 1'b0});
        wb(a);
        m.start();
        wb({DEV, 1'b1});
        for (int i = 0; i < n; i++) rb(i == n - 1);
        m.stop();
    endtask

    // cycles until the reset pin is pulled back up
    task automatic rel_chk(input int lo);
        int n;
        n = 0;
        while (rst_pin !== 1'b1 && n < 300) begin
            cyc(1);
            n++;
        end
        if (n >= 300) begin
            chk("release_done", 1'b1, 1'b0);
            results();
        end else begin
            chk("release_cycles", 1'b1, n >= lo && n <= lo + 8);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("rst_pin", 1'b0, rst_pin);
        chk("charge_on", 1'b0, c_on);
        resetn <= 1'b1;
        rel_chk(REL);
        rd(8'h00, 6);
        foreach (rq[i]) chk("reset_value", 8'h00, rq[i]);
    endtask

    task automatic t_map();
        logic [7:0] ex [7];
        ex = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'ha6, 8'h11};
        wq = '{8'h7f, 8'ha6, 8'h11, 8'h22, 8'h33, 8'h44};
        wr(8'h04);
        chk("write_ack", 1'b0, nak);
        rd(8'h00, 7);
        foreach (ex[i]) chk("read_byte", ex[i], rq[i]);
    endtask

    task automatic t_charge();
        logic [7:0] v [6];
        logic on;
        v = '{8'ha5, 8'hab, 8'ha3, 8'hae, 8'ha4, 8'h56};
        foreach (v[i]) begin
            wq = '{v[i]};
            wr(8'h05);
            cyc(2);
            on = v[i][7:4] == iscr_pkg::KEY_ENABLE && v[i][1:0] != iscr_pkg::RES_OFF
                 && (v[i][3:2] == iscr_pkg::DIODE_NONE || v[i][3:2] == iscr_pkg::DIODE_ONE);
            chk("charge_on", on, c_on);
            chk("charge_res", on ? v[i][1:0] : 2'h0, c_res);
            chk("charge_diode", on && v[i][3:2] == iscr_pkg::DIODE_ONE, c_d);
        end
    endtask

    // one tick short of a second during power fail, then a disabled edge
    task automatic t_tick();
        wq = '{8'hff, 8'hff, 8'hff, 8'h00};
        wr(8'h07);
        pf <= 1'b1;
        edges(32767);
        chk("rst_pin", 1'b0, rst_pin);
        wq = '{8'h00};
        wr(8'h00);
        chk("refused_ack", 1'b1, nak);
        pf <= 1'b0;
        rel_chk(REL);
        rd(8'h00, 4);
        chk("count", 32'h00ffffff, {rq[3], rq[2], rq[1], rq[0]});
        wq = '{8'h80};
        wr(8'h04);
        pf <= 1'b1;
        cyc(8);
        pf <= 1'b0;
        rel_chk(REL + STU);
        edges(1);
        rd(8'h00, 4);
        chk("count", 32'h00ffffff, {rq[3], rq[2], rq[1], rq[0]});
        wq = '{8'h00};
        wr(8'h04);
        edges(1);
        rd(8'h00, 4);
        chk("count", 32'h01000000, {rq[3], rq[2], rq[1], rq[0]});
    endtask

    initial begin
        cyc(3);
        t_reset();
        t_map();
        t_charge();
        t_tick();
        results();
    end
endmodule

bind iscr_top iscr_top_props #(.RELEASE_CYCLES(RELEASE_CYCLES), .STARTUP_CYCLES(STARTUP_CYCLES))
    u_props (.mclk(mclk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .crystal_in(crystal_in), .power_fail(power_fail),
    .rst_n_out(rst_n_out), .rst_n_oe(rst_n_oe), .charge_on(charge_on),
    .charge_diode(charge_diode), .charge_res(charge_res));

`default_nettype wire
